// ===== design/parallel_io_ports.v
// Overview of operation
// RULE_01: ports 0 and 1 split into byte halves
// RULE_02: port 2 sixteen bits; 4,6,7,8 eight
// RULE_03: port 3 fifteen lines, line 14 absent
// RULE_04: port 5 sixteen input-only lines
// RULE_05: ports 2,3,4,6,7,8 per-line open drain
// RULE_06: threshold choice only ports 2,3,4,7,8
// RULE_07: pins sampled every state time, any direction
// RULE_08: write to input line fills latch only
// RULE_09: read of input line returns pin
// RULE_10: modify on input uses pin, stores latch
// RULE_11: direction one enables the output driver
// RULE_12: read of output line returns latch
// RULE_13: modify on output uses latch, drives pin
// RULE_14: driver control registers for ports 0-4,6-8
// RULE_15: bus strobe drive bits in one register
// RULE_16: open-drain bits reset to push-pull
// RULE_17: threshold bit per byte of ports
// RULE_18: direction zero is input, reset input
`timescale 1ns/1ps
`include "pio_defs.vh"

module parallel_io_ports (
   input wire aclk,
   input wire aresetn,
   input wire [11:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [175:0] pin_in,
   output wire [175:0] pin_out,
   output wire [175:0] pin_oe_n,
   output wire [175:0] output_driver_ctrl,
   output reg [7:0] input_threshold_select,
   output reg [15:0] bus_strobe_driver_ctrl
);

   // ----------------------------------------------------------------
   // constants
   // ----------------------------------------------------------------
   localparam [175:0] SLOT_MASKS = `SLOT_MASKS;
   localparam [10:0] OUT_CAP = `SLOT_OUT_CAP;
   localparam [10:0] OD_CAP = `SLOT_OD_CAP;
   localparam [10:0] DRV_CAP = `SLOT_DRV_CAP;
   localparam [3:0] LAST_SLOT = 4'hA;

   // ----------------------------------------------------------------
   // write channel holding
   // ----------------------------------------------------------------
   reg aw_full_q;
   reg w_full_q;
   reg [11:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   // a write commits once both halves are held and no answer is pending
   wire commit = aw_full_q & w_full_q & ~s_axi_bvalid;

   // write address fields
   wire [1:0] w_top = aw_addr_q[`ADDR_TOP_HI:`ADDR_TOP_LO];
   wire [1:0] w_bank = aw_addr_q[`ADDR_BANK_HI:`ADDR_BANK_LO];
   wire [3:0] w_slot = aw_addr_q[`ADDR_SLOT_HI:`ADDR_SLOT_LO];
   wire [1:0] w_reg = aw_addr_q[`ADDR_REG_HI:`ADDR_REG_LO];

   // read address fields
   wire [1:0] r_top = s_axi_araddr[`ADDR_TOP_HI:`ADDR_TOP_LO];
   wire [1:0] r_bank = s_axi_araddr[`ADDR_BANK_HI:`ADDR_BANK_LO];
   wire [3:0] r_slot = s_axi_araddr[`ADDR_SLOT_HI:`ADDR_SLOT_LO];
   wire [1:0] r_reg = s_axi_araddr[`ADDR_REG_HI:`ADDR_REG_LO];

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   reg w_slot_ok;
   reg w_ctrl_ok;
   reg w_ok;

   // set and clear aliases exist only for the data word of a port slot
   always @* begin
      w_slot_ok = 1'b0;
      w_ctrl_ok = 1'b0;
      if (w_top == 2'h0) begin
         if (w_slot <= LAST_SLOT) begin
            if (w_bank == `BANK_PLAIN) begin
               w_slot_ok = 1'b1;
            end else if (w_bank != 2'h3 && w_reg == `REG_DATA) begin
               w_slot_ok = 1'b1;
            end
         end else if (w_slot == `SLOT_CTRL && w_bank == `BANK_PLAIN) begin
            w_ctrl_ok = (w_reg == `REG_THRESH) | (w_reg == `REG_STROBE);
         end
      end
      w_ok = w_slot_ok | w_ctrl_ok;
   end

   // ----------------------------------------------------------------
   // port slots
   // ----------------------------------------------------------------
   wire [175:0] view_all;
   wire [175:0] dir_all;
   wire [175:0] od_all;

   genvar g;
   generate
      for (g = 0; g < `SLOT_COUNT; g = g + 1) begin : slot
         wire slot_wr = commit & w_slot_ok & (w_slot == g);
         // RULE_01: port 0 and 1 halves own addresses
         // RULE_02: widths set by the slot masks
         // RULE_03: port 3 mask drops line 14
         port_slot #(
            .MASK(SLOT_MASKS[g*16 +: 16]),
            .OUT_CAP(OUT_CAP[g]),
            .OD_CAP(OD_CAP[g]),
            .DRV_CAP(DRV_CAP[g])
         ) u_slot (
            .aclk(aclk),
            .aresetn(aresetn),
            .pin_in(pin_in[g*16 +: 16]),
            .wr_en(slot_wr),
            .wr_reg(w_reg),
            .wr_bank(w_bank),
            .wdata(w_data_q[15:0]),
            .be(w_strb_q[1:0]),
            .view(view_all[g*16 +: 16]),
            .dir_q(dir_all[g*16 +: 16]),
            .od_q(od_all[g*16 +: 16]),
            .drv_q(output_driver_ctrl[g*16 +: 16]),
            .pin_out_q(pin_out[g*16 +: 16]),
            .pin_oe_n_q(pin_oe_n[g*16 +: 16])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // common control registers
   // ----------------------------------------------------------------
   wire ctrl_wr = commit & w_ctrl_ok;
   wire [15:0] ctrl_lane = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

   // threshold selects and bus strobe drive
   always @(posedge aclk) begin
      if (!aresetn) begin
         input_threshold_select <= `RST_THRESH;
         bus_strobe_driver_ctrl <= `RST_WORD;
      end else begin
         // RULE_06: only ports 2,3,4,7,8 bits
         // RULE_17: one bit per byte
         if (ctrl_wr && w_reg == `REG_THRESH && w_strb_q[0]) begin
            input_threshold_select <= w_data_q[7:0] & `THRESH_MASK;
         end
         // RULE_15: dedicated strobe drive bits
         if (ctrl_wr && w_reg == `REG_STROBE) begin
            bus_strobe_driver_ctrl <= (bus_strobe_driver_ctrl & ~(ctrl_lane & `STROBE_MASK))
               | (w_data_q[15:0] & ctrl_lane & `STROBE_MASK);
         end
      end
   end

   // ----------------------------------------------------------------
   // write channel handshake
   // ----------------------------------------------------------------
   // address and data are taken in either order, then held until the answer is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         aw_addr_q <= 12'h000;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (w_take) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (commit) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         // readiness returns only when the answer is taken: one write at a time
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------
   reg [15:0] r_word;
   reg r_ok;

   // the data word gives the direction-dependent view of each line
   always @(*) begin
      r_word = `ZERO16;
      r_ok = 1'b0;
      if (r_top == 2'h0 && r_bank == `BANK_PLAIN) begin
         if (r_slot <= LAST_SLOT) begin
            r_ok = 1'b1;
            case (r_reg)
               // RULE_09: view from input or output latch
               `REG_DATA: r_word = view_all[r_slot*16 +: 16];
               `REG_DIR: r_word = dir_all[r_slot*16 +: 16];
               `REG_OD: r_word = od_all[r_slot*16 +: 16];
               default: r_word = output_driver_ctrl[r_slot*16 +: 16];
            endcase
         end else if (r_slot == `SLOT_CTRL) begin
            case (r_reg)
               `REG_THRESH: begin
                  r_word = {8'h00, input_threshold_select};
                  r_ok = 1'b1;
               end
               `REG_STROBE: begin
                  r_word = bus_strobe_driver_ctrl;
                  r_ok = 1'b1;
               end
               default: begin
                  r_word = `ZERO16;
                  r_ok = 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // read channel handshake
   // ----------------------------------------------------------------
   // data is captured at the address edge, so a later pin change does not tear it
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, r_word};
            s_axi_rresp <= r_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// ===== design/pio_defs.vh
`ifndef PIO_DEFS_VH
`define PIO_DEFS_VH

// ----------------------------------------------------------------
// geometry of the port set
// ----------------------------------------------------------------
// slots: 0 port0 low, 1 port0 high, 2 port1 low, 3 port1 high,
// 4 port2, 5 port3, 6 port4, 7 port5, 8 port6, 9 port7, 10 port8
`define SLOT_COUNT 11
`define SLOT_W 16
`define PIN_BUS_W 176
// implemented lines per slot, slot 0 in the low bits
`define SLOT_MASKS 176'h00FF_00FF_00FF_FFFF_00FF_BFFF_FFFF_00FF_00FF_00FF_00FF
// slots with an output driver (all but the input-only port)
`define SLOT_OUT_CAP 11'h77F
// slots with per-line open-drain selection
`define SLOT_OD_CAP 11'h770
// slots with driver strength and edge-rate control
`define SLOT_DRV_CAP 11'h77F

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define ADDR_W 12
`define ADDR_BANK_HI 9
`define ADDR_BANK_LO 8
`define ADDR_SLOT_HI 7
`define ADDR_SLOT_LO 4
`define ADDR_REG_HI 3
`define ADDR_REG_LO 2
`define ADDR_TOP_HI 11
`define ADDR_TOP_LO 10
// register within a slot
`define REG_DATA 2'h0
`define REG_DIR 2'h1
`define REG_OD 2'h2
`define REG_DRV 2'h3
// banks: plain access, atomic set and atomic clear of the data word
`define BANK_PLAIN 2'h0
`define BANK_SET 2'h1
`define BANK_CLEAR 2'h2
// common control slot
`define SLOT_CTRL 4'hC
`define REG_THRESH 2'h0
`define REG_STROBE 2'h1

// ----------------------------------------------------------------
// field masks and reset values
// ----------------------------------------------------------------
`define THRESH_MASK 8'hDF
`define STROBE_MASK 16'h003F
`define RST_WORD 16'h0000
`define RST_OE_N 16'hFFFF
`define RST_THRESH 8'h00
`define ZERO16 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== design/port_slot.v
`timescale 1ns/1ps
`include "pio_defs.vh"

module port_slot #(
   parameter [15:0] MASK = 16'hFFFF,
   parameter [0:0] OUT_CAP = 1'b1,
   parameter [0:0] OD_CAP = 1'b1,
   parameter [0:0] DRV_CAP = 1'b1
) (
   input wire aclk,
   input wire aresetn,
   input wire [15:0] pin_in,
   input wire wr_en,
   input wire [1:0] wr_reg,
   input wire [1:0] wr_bank,
   input wire [15:0] wdata,
   input wire [1:0] be,
   output wire [15:0] view,
   output reg [15:0] dir_q,
   output reg [15:0] od_q,
   output reg [15:0] drv_q,
   output reg [15:0] pin_out_q,
   output reg [15:0] pin_oe_n_q
);

   // ----------------------------------------------------------------
   // write data shaping
   // ----------------------------------------------------------------
   reg [15:0] in_q;
   reg [15:0] out_q;
   reg [15:0] out_d;
   reg [15:0] dir_d;
   reg [15:0] od_d;
   reg [15:0] drv_d;
   wire [15:0] lane = {{8{be[1]}}, {8{be[0]}}};
   wire [15:0] wmask = lane & MASK;
   wire [15:0] wbits = wdata & wmask;
   // nibble fields exist for whole bytes, so the missing port3 line keeps its field
   wire [15:0] drv_mask = {{8{MASK[8]}}, 8'hFF} & lane;

   // RULE_09: input lines read the sampled level
   // RULE_12: output lines read the output latch
   assign view = ((dir_q & out_q) | (~dir_q & in_q)) & MASK;

   // next-state of the software registers
   always @* begin
      out_d = out_q;
      dir_d = dir_q;
      od_d = od_q;
      drv_d = drv_q;
      if (wr_en && wr_reg == `REG_DATA) begin
         case (wr_bank)
            // RULE_10: operand is pin for inputs
            // RULE_13: operand is latch for outputs
            `BANK_SET: begin
               out_d = (out_q & ~wmask) | ((view | wbits) & wmask);
            end
            `BANK_CLEAR: begin
               out_d = (out_q & ~wmask) | (view & ~wbits & wmask);
            end
            // RULE_08: latch stored even for inputs
            default: begin
               out_d = (out_q & ~wmask) | wbits;
            end
         endcase
      end
      // RULE_04: input-only slot keeps no direction
      if (wr_en && wr_reg == `REG_DIR && OUT_CAP) begin
         dir_d = (dir_q & ~wmask) | wbits;
      end
      // RULE_05: per-line open-drain choice
      if (wr_en && wr_reg == `REG_OD && OD_CAP) begin
         od_d = (od_q & ~wmask) | wbits;
      end
      // RULE_14: driver strength and edge fields
      if (wr_en && wr_reg == `REG_DRV && DRV_CAP) begin
         drv_d = (drv_q & ~drv_mask) | (wdata & drv_mask);
      end
   end

   // ----------------------------------------------------------------
   // state and pad drive
   // ----------------------------------------------------------------
   // pad controls are registered from the next values so they move with the latch
   always @(posedge aclk) begin
      if (!aresetn) begin
         in_q <= `RST_WORD;
         out_q <= `RST_WORD;
         // RULE_18: direction resets to input
         dir_q <= `RST_WORD;
         // RULE_16: push-pull after reset
         od_q <= `RST_WORD;
         drv_q <= `RST_WORD;
         pin_out_q <= `RST_WORD;
         pin_oe_n_q <= `RST_OE_N;
      end else begin
         // RULE_07: every line sampled each cycle
         in_q <= pin_in & MASK;
         out_q <= out_d;
         dir_q <= dir_d;
         od_q <= od_d;
         drv_q <= drv_d;
         pin_out_q <= out_d;
         // RULE_11: driver on when direction is one
         // RULE_16: open drain drives only the low level
         pin_oe_n_q <= ~(dir_d & (~od_d | ~out_d));
      end
   end

endmodule

// ===== tb/pin_board.sv
`timescale 1ns/1ps

module pin_board (
   input wire [175:0] pin_out,
   input wire [175:0] pin_oe_n,
   input wire [175:0] ext,
   output wire [175:0] pin_in
);
   // driven lines follow the pad, released lines follow the board
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);
endmodule

// ===== tb/pio_properties.sv
`timescale 1ns/1ps
`include "pio_defs.vh"

module pio_properties (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [175:0] pin_out,
   input wire [175:0] pin_oe_n,
   input wire [7:0] input_threshold_select,
   input wire [15:0] bus_strobe_driver_ctrl
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // both write channels taken on one edge, answer two edges on
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_answer;
      ##2 s_axi_bvalid;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence

   AST_WR_ANSWER: assert property (s_wr_take |-> s_wr_answer)
      else $error("write answer missing");
   AST_PIN_ON_COMMIT: assert property ((!$stable(pin_out) || !$stable(pin_oe_n))
      |-> $rose(s_axi_bvalid))
      else $error("pad outputs moved without a write");
   AST_RD_ANSWER: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read answer missing");
   AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_INPUT_ONLY: assert property (&pin_oe_n[127:112])
      else $error("input-only port driven");
   AST_LINE_ABSENT: assert property (pin_oe_n[94])
      else $error("absent line driven");
   AST_PORT_WIDTH: assert property ((~pin_oe_n & ~`SLOT_MASKS) == 176'h0)
      else $error("line outside port width driven");
   AST_THRESH_GAP: assert property (!input_threshold_select[5])
      else $error("threshold bit for port without choice set");
   AST_STROBE_FIELD: assert property (bus_strobe_driver_ctrl[15:6] == 10'h000)
      else $error("strobe driver spare bits set");
endmodule

// ===== tb/test_parallel_io_ports.sv
`timescale 1ns/1ps
`include "pio_defs.vh"

module test_parallel_io_ports;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr, a;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [175:0] pin_in, pin_out, pin_oe_n, output_driver_ctrl, ext;
   logic [7:0] input_threshold_select;
   logic [15:0] bus_strobe_driver_ctrl, p, l, dirv, m, e;
   int fails, tests_run;

   parallel_io_ports u_parallel_io_ports (.*);
   pin_board u_pin_board (.*);

   // -------------------------------------------------
   // helpers
   // -------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // bready is raised with the request; it only matters once bvalid shows
   task automatic axi_wr(input logic [11:0] ad, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid && n < 50);
      s_axi_bready <= 1'h0;
      rsp = s_axi_bresp;
      if (!s_axi_bvalid) begin
         fails++;
         report_and_stop;
      end
   endtask

   task automatic axi_rd(input logic [11:0] ad);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid && n < 50);
      s_axi_rready <= 1'h0;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      if (!s_axi_rvalid) begin
         fails++;
         report_and_stop;
      end
   endtask

   function automatic logic [15:0] smask(input int s);
      logic [175:0] mk;
      mk = `SLOT_MASKS;
      return mk[s*16 +: 16];
   endfunction

   // input-only port ignores direction; absent lines read 0
   function automatic logic [15:0] exp_rd(input int s, input logic [15:0] d, lt, pn);
      if (s == 7) d = 16'h0000;
      return ((d & lt) | (~d & pn)) & smask(s);
   endfunction

   // -------------------------------------------------
   // clock, timeout and main sequence
   // -------------------------------------------------
   initial begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end

   initial begin
      repeat (30000) @(posedge aclk);
      fails++;
      report_and_stop;
   end

   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      ext = '0;
      aresetn = 1'h0;
      fails = 0;
      tests_run = 0;
      void'($urandom(41204));
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      for (int s = 0; s < 11; s++) begin
         a = 12'(s * 16);
         {p, l, dirv, m} = {16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom)};
         ext[s*16 +: 16] <= p;
         axi_rd(a + 12'h004);
         chk(rd, 32'h0);
         axi_rd(a + 12'h008);
         chk(rd, 32'h0);
         axi_wr(a, l);
         chk(pin_oe_n[s*16 +: 16], 16'hFFFF);
         axi_rd(a);
         chk(rd, exp_rd(s, 16'h0000, l, p));
         axi_wr(a + 12'h004, dirv);
         chk(rsp, `RESP_OKAY);
         axi_rd(a);
         chk(rd, exp_rd(s, dirv, l, p));
         e = (s == 7) ? 16'h0000 : dirv & smask(s);
         chk(16'(~pin_oe_n[s*16 +: 16]), e);
         chk(pin_out[s*16 +: 16] & e, l & e);
         // set through the alias, then clear, then view as outputs
         axi_wr(a + 12'h100, m);
         l = exp_rd(s, dirv, l, p) | m;
         axi_rd(a);
         chk(rd, exp_rd(s, dirv, l, p));
         m = 16'($urandom);
         axi_wr(a + 12'h200, m);
         l = exp_rd(s, dirv, l, p) & ~m;
         axi_wr(a + 12'h004, 16'hFFFF);
         axi_rd(a);
         chk(rd, exp_rd(s, 16'hFFFF, l, p));
         axi_wr(a + 12'h008, smask(s));
         axi_rd(a + 12'h008);
         e = (s > 3 && s != 7) ? smask(s) : 16'h0000;
         chk(rd, e);
         e = (s == 7) ? 16'h0000 : ((e == 16'h0000) ? smask(s) : ~l & smask(s));
         chk(16'(~pin_oe_n[s*16 +: 16]), e);
         m = 16'($urandom) & 16'h00FF;
         axi_wr(a + 12'h00C, m);
         axi_rd(a + 12'h00C);
         chk(rd, (s == 7) ? 32'h0 : m);
      end
      axi_wr(12'h0C0, 16'hFFFF);
      axi_rd(12'h0C0);
      chk(rd, 32'hDF);
      chk(input_threshold_select, 8'hDF);
      axi_wr(12'h0C4, 16'hFFFF);
      axi_rd(12'h0C4);
      chk(rd, 32'h3F);
      // unmapped places and set on a non-data register
      axi_wr(12'h0D0, 16'hFFFF);
      chk(rsp, `RESP_SLVERR);
      axi_wr(12'h104, 16'hFFFF);
      chk(rsp, `RESP_SLVERR);
      axi_rd(12'hC00);
      chk(rsp, `RESP_SLVERR);
      // second reset in mid-run
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk({31'h0, &pin_oe_n}, 32'h1);
      axi_rd(12'h048);
      chk(rd, 32'h0);
      report_and_stop;
   end
endmodule

bind parallel_io_ports pio_properties u_pio_properties (.*);
